/* File: logic/sspc_core.sv */
// serial port control block: apb registers, prescaler, shifter, pins
// Notes on behaviour
// [R1] clock pin disable releases clock pin
// [R2] data out disable releases data pin
// [R3] sixteen or eight bits per transfer
// [R4] controller samples middle or end of bit
// [R5] clock edge select picks output change edge
// [R6] target select pin used only when enabled
// [R7] polarity sets serial clock idle level
// [R8] role select: controller drives clock, target follows
// [R9] secondary prescale divides one to eight
// [R10] primary prescale divides 1,4,16,64 cascaded
// [R11] software never sets both prescalers 1:1
// [R12] software clears edge select when framed
// [R13] software clears select enable when framed
// [R14] framed mode turns select pin into sync
// [R15] sync direction: input target, output controller
// [R16] sync polarity picks active level
// [R17] sync coincident with or one bit before
// [R18] module enable claims pins, clear disables
// [R19] unread data: discard new, set overflow
// [R20] data write sets transmit full flag
// [R21] received word sets receive full flag
`timescale 1ns/100ps
module sspc_core #(
  parameter int unsigned ADDR_W = 8
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // serial pins
  input wire logic i_sck,
  input wire logic i_sdi,
  input wire logic i_ss_n,
  output sspc_pkg::sspc_pin_s o_sck,
  output sspc_pkg::sspc_pin_s o_sdo,
  output sspc_pkg::sspc_pin_s o_ss
);

  sspc_pkg::sspc_ctl1_s ctl1_q, ctl1_d;
  sspc_pkg::sspc_ctl2_s ctl2_q, ctl2_d;
  sspc_pkg::sspc_state_e state_q, state_d;
  logic en_q, en_d, tbf_q, tbf_d, rbf_q, rbf_d, rov_q, rov_d;
  logic [15:0] tx_hold_q, tx_hold_d, tx_sh_q, tx_sh_d, rx_hold_q, rx_hold_d, rx_sh_q, rx_sh_d;
  logic [3:0] bit_q, bit_d;
  logic [9:0] div_q, div_d, presc;
  logic half_q, half_d, sdo_q, sdo_d, sck_q, sck_d, fs_q, fs_d, armed_q, armed_d;
  logic [31:0] prdata_q, prdata_d;
  logic [2:0] s1_q, s2_q, s3_q, f_q, f_d;
  logic [7:0] addr;
  logic acc, mapped, wr, rd_data, ctrl, tick, sample, change, load, complete;
  logic sel, fs_active, lead, trail, last_bit;
  logic [15:0] rx_next, rx_word;
  logic [3:0] last_idx;

  // apb decode, zero wait states
  assign addr = i_paddr[7:0];
  assign mapped = (addr == sspc_pkg::OFF_STATUS) || (addr == sspc_pkg::OFF_CTL1) ||
                  (addr == sspc_pkg::OFF_CTL2) || (addr == sspc_pkg::OFF_DATA);
  assign acc = i_psel && i_penable;
  assign wr = acc && i_pwrite && mapped;
  assign rd_data = acc && !i_pwrite && (addr == sspc_pkg::OFF_DATA);
  assign o_pready = 1'b1;
  assign o_pslverr = acc && !mapped;
  assign o_prdata = prdata_q;

  // pin filter: a level counts once the second and third stages agree
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      f_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : f_q[i];
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      // select pin rests high, so no false select right after reset
      s1_q <= 3'h4;
      s2_q <= 3'h4;
      s3_q <= 3'h4;
      f_q <= 3'h4;
    end else begin
      s1_q <= {i_ss_n, i_sdi, i_sck};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= f_d;
    end
  end

  // derived controls shared by both roles
  assign ctrl = ctl1_q.controller_role_enable; // R8
  assign presc = sspc_pkg::sspc_half_cycles(ctl1_q.primary_prescale,
                                            ctl1_q.secondary_prescale); // R9 R10
  assign tick = (div_q == presc - 10'h001);
  assign last_idx = ctl1_q.word_width_select ? sspc_pkg::LAST_BIT_WORD
                                             : sspc_pkg::LAST_BIT_BYTE; // R3
  assign last_bit = (bit_q == last_idx);
  // filtered input lags the pin by four cycles: half cells under five read stale data
  assign rx_next = {rx_sh_q[14:0], f_q[1]};
  assign rx_word = ctl1_q.word_width_select ? rx_sh_d : {8'h00, rx_sh_d[7:0]}; // R3
  assign fs_active = ctl2_q.frame_sync_polarity ? f_q[2] : !f_q[2]; // R16
  assign sel = ctl2_q.framed_enable || !ctl1_q.select_pin_enable || !f_q[2]; // R6 R14
  assign lead = (f_d[0] != f_q[0]) && (f_d[0] != ctl1_q.clock_polarity);
  assign trail = (f_d[0] != f_q[0]) && (f_d[0] == ctl1_q.clock_polarity);

  // next state: registers, sequencer, shifter and flags
  always_comb begin
    ctl1_d = ctl1_q;
    ctl2_d = ctl2_q;
    en_d = en_q;
    state_d = state_q;
    tbf_d = tbf_q;
    rbf_d = rbf_q;
    rov_d = rov_q;
    tx_hold_d = tx_hold_q;
    tx_sh_d = tx_sh_q;
    rx_hold_d = rx_hold_q;
    rx_sh_d = rx_sh_q;
    bit_d = bit_q;
    div_d = div_q;
    half_d = half_q;
    sdo_d = sdo_q;
    fs_d = fs_q;
    armed_d = armed_q;
    prdata_d = prdata_q;
    sample = 1'b0;
    change = 1'b0;
    load = 1'b0;
    complete = 1'b0;
    if (!en_q) begin
      state_d = sspc_pkg::ST_IDLE; // R18
      bit_d = 4'h0;
      half_d = 1'b0;
      div_d = 10'h000;
      fs_d = 1'b0;
      armed_d = 1'b0;
    end else if (ctrl) begin
      // controller: each bit cell is two prescaled halves
      div_d = (state_q == sspc_pkg::ST_IDLE || tick) ? 10'h000 : div_q + 10'h001;
      armed_d = 1'b0;
      case (state_q)
        sspc_pkg::ST_IDLE: begin
          bit_d = 4'h0;
          half_d = 1'b0;
          if (tbf_q) begin
            load = 1'b1;
            if (ctl2_q.framed_enable && !ctl2_q.frame_sync_direction) begin
              fs_d = 1'b1; // R15
            end
            if (ctl2_q.framed_enable && !ctl2_q.frame_sync_direction &&
                !ctl2_q.frame_sync_edge) begin
              state_d = sspc_pkg::ST_SYNC; // R17
            end else begin
              state_d = sspc_pkg::ST_SHIFT;
              change = 1'b1;
            end
          end
        end
        sspc_pkg::ST_SYNC: begin
          if (tick) begin
            half_d = !half_q;
            if (half_q) begin
              state_d = sspc_pkg::ST_SHIFT; // R17
              change = 1'b1;
              fs_d = 1'b0;
            end
          end
        end
        sspc_pkg::ST_SHIFT: begin
          if (tick) begin
            half_d = !half_q;
            sample = (half_q == ctl1_q.sample_phase); // R4
            if (half_q) begin
              fs_d = 1'b0;
              if (last_bit) begin
                state_d = sspc_pkg::ST_IDLE;
                complete = 1'b1;
              end else begin
                bit_d = bit_q + 4'h1;
                change = 1'b1;
              end
            end
          end
        end
        default: begin
          state_d = sspc_pkg::ST_IDLE;
        end
      endcase
    end else begin
      // target: follow the filtered external clock
      state_d = sspc_pkg::ST_IDLE;
      div_d = 10'h000;
      half_d = 1'b0;
      fs_d = 1'b0;
      if (!sel) begin
        bit_d = 4'h0; // R6
        armed_d = 1'b0;
      end else begin
        sample = ctl1_q.clock_edge_select ? lead : trail; // R5
        change = ctl1_q.clock_edge_select ? (trail && bit_q != 4'h0) : lead; // R5
        if (ctl2_q.framed_enable && ctl2_q.frame_sync_direction && !armed_q) begin
          change = 1'b0;
          if (sample && fs_active) begin
            armed_d = 1'b1; // R14 R15
            sample = ctl2_q.frame_sync_edge; // R17
          end else begin
            sample = 1'b0;
          end
        end
        if (bit_q == 4'h0 && tbf_q && !sample) begin
          load = 1'b1;
          change = change || ctl1_q.clock_edge_select;
        end
        if (sample) begin
          if (last_bit) begin
            complete = 1'b1;
            bit_d = 4'h0;
            armed_d = 1'b0;
          end else begin
            bit_d = bit_q + 4'h1;
          end
        end
      end
    end
    // shift register moves
    if (load) begin
      tx_sh_d = ctl1_q.word_width_select ? tx_hold_q : {tx_hold_q[7:0], 8'h00};
      tbf_d = 1'b0; // R20
    end
    if (change) begin
      sdo_d = tx_sh_d[sspc_pkg::MSB_IDX - bit_d];
    end
    if (sample) begin
      rx_sh_d = rx_next;
    end
    // receive hold and flags
    if (rd_data) begin
      rbf_d = 1'b0; // R21
    end
    if (complete) begin
      if (rbf_q && !rd_data) begin
        rov_d = 1'b1; // R19
      end else begin
        rx_hold_d = ctl1_q.word_width_select ? rx_sh_d : {8'h00, rx_sh_d[7:0]}; // R21
        rbf_d = 1'b1;
      end
    end
    // register writes, the overflow clear losing to a new overflow
    if (wr) begin
      case (addr)
        sspc_pkg::OFF_STATUS: begin
          en_d = i_pwdata[sspc_pkg::STAT_EN_BIT]; // R18
          if (!i_pwdata[sspc_pkg::STAT_ROV_BIT] && !(complete && rbf_q && !rd_data)) begin
            rov_d = 1'b0; // R19
          end
        end
        sspc_pkg::OFF_CTL1: ctl1_d = i_pwdata[15:0] & sspc_pkg::CTL1_MASK;
        sspc_pkg::OFF_CTL2: ctl2_d = i_pwdata[15:0] & sspc_pkg::CTL2_MASK;
        sspc_pkg::OFF_DATA: begin
          tx_hold_d = i_pwdata[15:0];
          tbf_d = 1'b1; // R20
        end
        default: begin
          en_d = en_q;
        end
      endcase
    end
    // read data captured in the setup cycle
    if (i_psel && !i_penable && !i_pwrite) begin
      case (addr)
        sspc_pkg::OFF_STATUS: begin
          prdata_d = 32'h0000_0000;
          prdata_d[sspc_pkg::STAT_EN_BIT] = en_q;
          prdata_d[sspc_pkg::STAT_ROV_BIT] = rov_q;
          prdata_d[sspc_pkg::STAT_TBF_BIT] = tbf_q;
          prdata_d[sspc_pkg::STAT_RBF_BIT] = rbf_q;
        end
        sspc_pkg::OFF_CTL1: prdata_d = {16'h0000, ctl1_q};
        sspc_pkg::OFF_CTL2: prdata_d = {16'h0000, ctl2_q};
        sspc_pkg::OFF_DATA: prdata_d = {16'h0000, rx_hold_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  // controller clock level from the next cell position
  assign sck_d = ctl1_q.clock_polarity ^ ((state_d != sspc_pkg::ST_IDLE) &&
                 (ctl1_q.clock_edge_select ? half_d : !half_d)); // R5 R7

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctl1_q <= sspc_pkg::CTL1_RST;
      ctl2_q <= sspc_pkg::CTL2_RST;
      en_q <= 1'b0;
      state_q <= sspc_pkg::ST_IDLE;
      tbf_q <= 1'b0;
      rbf_q <= 1'b0;
      rov_q <= 1'b0;
      tx_hold_q <= 16'h0000;
      tx_sh_q <= 16'h0000;
      rx_hold_q <= 16'h0000;
      rx_sh_q <= 16'h0000;
      bit_q <= 4'h0;
      div_q <= 10'h000;
      half_q <= 1'b0;
      sdo_q <= 1'b0;
      sck_q <= 1'b0;
      fs_q <= 1'b0;
      armed_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      ctl1_q <= ctl1_d;
      ctl2_q <= ctl2_d;
      en_q <= en_d;
      state_q <= state_d;
      tbf_q <= tbf_d;
      rbf_q <= rbf_d;
      rov_q <= rov_d;
      tx_hold_q <= tx_hold_d;
      tx_sh_q <= tx_sh_d;
      rx_hold_q <= rx_hold_d;
      rx_sh_q <= rx_sh_d;
      bit_q <= bit_d;
      div_q <= div_d;
      half_q <= half_d;
      sdo_q <= sdo_d;
      sck_q <= sck_d;
      fs_q <= fs_d;
      armed_q <= armed_d;
      prdata_q <= prdata_d;
    end
  end

  // pin drivers and enables
  assign o_sck.o = sck_q;
  assign o_sck.oe = en_q && ctrl && !ctl1_q.clock_pin_disable; // R1 R8 R18
  assign o_sdo.o = sdo_q;
  assign o_sdo.oe = en_q && !ctl1_q.data_out_pin_disable && (ctrl || sel); // R2 R6
  assign o_ss.o = ctl2_q.frame_sync_polarity ? fs_q : !fs_q; // R16
  assign o_ss.oe = en_q && ctrl && ctl2_q.framed_enable &&
                   !ctl2_q.frame_sync_direction; // R14 R15

  // checks
  logic [9:0] half_len_q;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      half_len_q <= 10'h000;
    end else begin
      half_len_q <= (half_d != half_q || state_q == sspc_pkg::ST_IDLE) ? 10'h000
                                                                        : half_len_q + 10'h001;
    end
  end

  // samples taken since the last finished word
  logic [4:0] nsamp_q;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      nsamp_q <= 5'h00;
    end else if (complete || !en_q || (ctrl && state_q == sspc_pkg::ST_IDLE) ||
                 (!ctrl && !sel)) begin
      nsamp_q <= 5'h00;
    end else if (sample) begin
      nsamp_q <= nsamp_q + 5'h01;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  sequence s_data_write;
    wr && addr == sspc_pkg::OFF_DATA;
  endsequence
  sequence s_tbf_pending;
    tbf_q ##0 tx_hold_q == $past(i_pwdata[15:0]);
  endsequence

  a_tbf_on_write: assert property (s_data_write |=> s_tbf_pending) // R20
    else $error("transmit full not set by data write");
  a_rbf_on_read: assert property (rd_data && !complete |=> !rbf_q) // R21
    else $error("receive full not cleared by read");
  a_overflow_keeps: assert property (complete && rbf_q && !rd_data |=>
                                     rov_q && $stable(rx_hold_q)) // R19
    else $error("overflow did not discard new data");
  a_complete_stores: assert property (complete && !rbf_q |=> // R21
                                      rbf_q && rx_hold_q == $past(rx_word))
    else $error("received word not stored");
  a_sck_pin_release: assert property (ctl1_q.clock_pin_disable || !en_q |-> !o_sck.oe) // R1
    else $error("clock pin driven while released");
  a_sdo_pin_release: assert property (ctl1_q.data_out_pin_disable |-> !o_sdo.oe) // R2
    else $error("data pin driven while released");
  a_idle_level: assert property (state_q == sspc_pkg::ST_IDLE && $stable(ctl1_q) |->
                                 o_sck.o == ctl1_q.clock_polarity) // R7
    else $error("serial clock not at idle level");
  a_half_period: assert property (state_q == sspc_pkg::ST_SHIFT && half_d != half_q &&
                                  $stable(ctl1_q) |-> half_len_q + 10'h001 == presc) // R9 R10
    else $error("half bit cell length wrong");
  a_width_count: assert property (complete |-> bit_q == last_idx && // R3
                                  nsamp_q + {4'h0, sample} == {1'b0, last_idx} + 5'h01)
    else $error("transfer length wrong");
  a_frame_lead: assert property (state_q == sspc_pkg::ST_SYNC |->
                                 o_ss.oe && o_ss.o == ctl2_q.frame_sync_polarity) // R17
    else $error("frame sync not active before first bit");

endmodule

/* File: logic/sspc_pkg.sv */
// constants, field layouts and helpers for the serial port control block
package sspc_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_CTL1 = 8'h04;
  localparam logic [7:0] OFF_CTL2 = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0c;

  // status register bit positions
  localparam int unsigned STAT_EN_BIT = 15;
  localparam int unsigned STAT_ROV_BIT = 6;
  localparam int unsigned STAT_TBF_BIT = 1;
  localparam int unsigned STAT_RBF_BIT = 0;

  // reset values and writable masks
  localparam logic [15:0] CTL1_RST = 16'h0000;
  localparam logic [15:0] CTL2_RST = 16'h0000;
  localparam logic [15:0] CTL1_MASK = 16'h1fff;
  localparam logic [15:0] CTL2_MASK = 16'he002;

  // last bit index for word and byte transfers
  localparam logic [3:0] LAST_BIT_WORD = 4'hf;
  localparam logic [3:0] LAST_BIT_BYTE = 4'h7;
  localparam logic [3:0] MSB_IDX = 4'hf;

  // control register one layout
  typedef struct packed {
    logic [2:0] rsv;
    logic clock_pin_disable;
    logic data_out_pin_disable;
    logic word_width_select;
    logic sample_phase;
    logic clock_edge_select;
    logic select_pin_enable;
    logic clock_polarity;
    logic controller_role_enable;
    logic [2:0] secondary_prescale;
    logic [1:0] primary_prescale;
  } sspc_ctl1_s;

  // control register two layout
  typedef struct packed {
    logic framed_enable;
    logic frame_sync_direction;
    logic frame_sync_polarity;
    logic [10:0] rsv_hi;
    logic frame_sync_edge;
    logic rsv_lo;
  } sspc_ctl2_s;

  // one pin: output level and its enable
  typedef struct packed {
    logic o;
    logic oe;
  } sspc_pin_s;

  // controller sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SYNC = 2'b01,
    ST_SHIFT = 2'b10
  } sspc_state_e;

  // system clocks per half bit cell: primary times secondary ratio
  function automatic logic [9:0] sspc_half_cycles(input logic [1:0] pri, input logic [2:0] sec);
    logic [9:0] p;
    logic [9:0] s;
    logic [19:0] prod;
    p = 10'h001 << {~pri, 1'b0};
    s = 10'h008 - {7'h00, sec};
    prod = p * s;
    return prod[9:0];
  endfunction

endpackage

/* File: verification/sspc_core_tb.sv */
// self-checking bench for the serial port control block
`timescale 1ns/100ps
module sspc_core_tb;
  localparam logic [7:0] AST = sspc_pkg::OFF_STATUS;
  localparam logic [7:0] AC1 = sspc_pkg::OFF_CTL1;
  localparam logic [7:0] AC2 = sspc_pkg::OFF_CTL2;
  localparam logic [7:0] ADB = sspc_pkg::OFF_DATA;
  // clock, reset and apb
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic perr;
  // pins and partner controls
  logic ss_n = 1'b1;
  logic sdi;
  sspc_pkg::sspc_pin_s sck;
  sspc_pkg::sspc_pin_s sdo;
  sspc_pkg::sspc_pin_s ss;
  logic p_pol = 1'b0;
  logic p_edge = 1'b0;
  logic p_ld = 1'b0;
  logic [4:0] p_n = 5'h08;
  logic [15:0] p_tx = 16'h0;
  logic [15:0] p_rx;
  logic [4:0] p_cnt;
  logic [1:0] p_skip = 2'h0;
  // bench state
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int half = 1;
  int run = 0;
  int per = 0;
  logic sck_l = 1'b0;
  logic ss_hi = 1'b0;
  logic [31:0] seed = 32'h0c4a11c9;
  logic [15:0] rx_q[$];
  logic [31:0] r;
  sspc_pkg::sspc_ctl1_s c1;
  // rows: polarity, edge, word, sample phase, primary, secondary
  logic [8:0] rows[4] = '{9'b000010110, 9'b101011010, 9'b011101000, 9'b110000111};

  always #12.5 clk = ~clk;

  sspc_core dut_u (.i_mclk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_sck(1'b0), .i_sdi(sdi), .i_ss_n(ss_n), .o_sck(sck), .o_sdo(sdo),
    .o_ss(ss));
  sspc_partner peer_u (.i_sck(sck.o), .i_sdo(sdo.o), .o_sdi(sdi), .i_pol(p_pol),
    .i_edge(p_edge), .i_n(p_n), .i_tx(p_tx), .i_load(p_ld), .i_skip(p_skip), .o_rx(p_rx),
    .o_cnt(p_cnt));

  // serial clock half period, sync pulse seen, hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (sck.o !== sck_l) begin
      per <= run + 1;
      run <= 0;
    end else begin
      run <= run + 1;
    end
    sck_l <= sck.o;
    if (ss.o === 1'b1) ss_hi <= 1'b1;
    if (cyc == 40000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic test_done();
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // one apb transfer: setup, access until pready, then idle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask

  task automatic cfg(input logic [8:0] w);
    c1 = '0;
    c1.clock_polarity = w[8];
    c1.clock_edge_select = w[7];
    c1.word_width_select = w[6];
    c1.sample_phase = w[5];
    c1.controller_role_enable = 1'b1;
    c1.primary_prescale = w[4:3];
    c1.secondary_prescale = w[2:0];
    half = (4 ** (3 - int'(w[4:3]))) * (8 - int'(w[2:0]));
    p_pol <= w[8];
    p_edge <= w[7];
    apb(1'b1, AC1, {16'h0, c1});
    apb(1'b1, AST, 32'h0000_8000);
  endtask

  // one word each way; en writes data while disabled, then enables
  task automatic xfer(input logic en);
    logic [15:0] d;
    logic [15:0] m;
    m = c1.word_width_select ? 16'hffff : 16'h00ff;
    d = 16'(rnd());
    p_n <= c1.word_width_select ? 5'h10 : 5'h08;
    p_tx <= 16'(rnd());
    p_ld <= 1'b1;
    @(posedge clk);
    p_ld <= 1'b0;
    apb(1'b1, ADB, {16'h0, d});
    if (en) begin
      rdc(AST, 32'h0000_0002);
      apb(1'b1, AST, 32'h0000_8000);
    end
    while (p_cnt !== p_n) begin
      @(posedge clk);
    end
    repeat (2 * half + 12) @(posedge clk);
    chk({16'h0, p_rx & m}, {16'h0, d & m});
    rx_q.push_back(p_tx & m);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // reset state, masks and an unmapped place
    chk({28'h0, sck.oe, sdo.oe, ss.oe, ss.o}, 32'h1);
    rdc(AST, 32'h0);
    rdc(AC1, 32'h0);
    rdc(AC2, 32'h0);
    apb(1'b1, AC1, 32'hffff_ffff);
    apb(1'b1, AC2, 32'hffff_ffff);
    rdc(AC1, {16'h0, sspc_pkg::CTL1_MASK});
    rdc(AC2, {16'h0, sspc_pkg::CTL2_MASK});
    rdc(8'h10, 32'h0);
    chk({31'h0, perr}, 32'h1);
    apb(1'b1, AC2, 32'h0);
    $display("test regs done");
    // transmit full while disabled, then transfer
    cfg(rows[0]);
    apb(1'b1, AST, 32'h0);
    xfer(1'b1);
    rdc(ADB, {16'h0, rx_q.pop_front()});
    $display("test hold done");
    // every polarity, edge, width and primary prescale code row
    for (int i = 0; i < 4; i++) begin
      cfg(rows[i]);
      xfer(1'b0);
      chk({29'h0, sck.oe, sdo.oe, sck.o}, {29'h0, 2'b11, p_pol});
      chk(per, half);
      rdc(AST, 32'h0000_8001);
      rdc(ADB, {16'h0, rx_q.pop_front()});
      rdc(AST, 32'h0000_8000);
      $display("test row %0d done", i);
    end
    // second word while the first is unread
    cfg(rows[0]);
    xfer(1'b0);
    xfer(1'b0);
    void'(rx_q.pop_back());
    rdc(AST, 32'h0000_8041);
    rdc(ADB, {16'h0, rx_q.pop_front()});
    apb(1'b1, AST, 32'h0000_8000);
    rdc(AST, 32'h0000_8000);
    $display("test overflow done");
    // framed, sync output active high, coincident with first bit
    apb(1'b1, AC2, 32'h0000_a002);
    ss_hi <= 1'b0;
    xfer(1'b0);
    chk({30'h0, ss.oe, ss_hi}, 32'h3);
    rdc(ADB, {16'h0, rx_q.pop_front()});
    // framed, sync one bit cell ahead of the first bit
    apb(1'b1, AC2, 32'h0000_a000);
    ss_hi <= 1'b0;
    p_skip <= 2'h2;
    xfer(1'b0);
    chk({30'h0, ss.oe, ss_hi}, 32'h3);
    rdc(ADB, {16'h0, rx_q.pop_front()});
    p_skip <= 2'h0;
    apb(1'b1, AC2, 32'h0);
    $display("test framed done");
    // pin release, target role with select pin, module off
    c1.clock_pin_disable = 1'b1;
    c1.data_out_pin_disable = 1'b1;
    apb(1'b1, AC1, {16'h0, c1});
    chk({30'h0, sck.oe, sdo.oe}, 32'h0);
    c1 = '0;
    c1.select_pin_enable = 1'b1;
    apb(1'b1, AC1, {16'h0, c1});
    chk({30'h0, sck.oe, sdo.oe}, 32'h0);
    ss_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk({30'h0, sck.oe, sdo.oe}, 32'h1);
    apb(1'b1, AST, 32'h0);
    chk({30'h0, sck.oe, sdo.oe}, 32'h0);
    $display("test pins done");
    test_done();
  end
endmodule

/* File: verification/sspc_partner.sv */
// behavioural serial target facing the controller clock and data pins
`timescale 1ns/100ps
module sspc_partner (
  // pin side
  input wire logic i_sck,
  input wire logic i_sdo,
  output logic o_sdi,
  // settings and word from the bench
  input wire logic i_pol,
  input wire logic i_edge,
  input wire logic [4:0] i_n,
  input wire logic [15:0] i_tx,
  input wire logic i_load,
  input wire logic [1:0] i_skip,
  output logic [15:0] o_rx,
  output logic [4:0] o_cnt
);
  // start level before the first load
  initial begin
    o_sdi = 1'b0;
    o_cnt = 5'h00;
    o_rx = 16'h0000;
  end
  // sync cell clock transitions still to be let pass
  int skip = 0;
  // sample on one clock transition, change data on the other
  always @(i_sck or posedge i_load) begin
    if (i_load) begin
      skip = int'(i_skip);
      o_cnt = 5'h00;
      o_rx = 16'h0000;
      o_sdi = i_tx[i_n - 5'h01];
    end else if (skip > 0) begin
      skip = skip - 1;
    end else if ((i_sck != i_pol) == i_edge) begin
      o_rx = {o_rx[14:0], i_sdo};
      o_cnt = o_cnt + 5'h01;
    end else if (o_cnt < i_n) begin
      o_sdi = i_tx[i_n - 5'h01 - o_cnt];
    end else begin
      o_sdi = ~o_sdi; // released line shows the inverse
    end
  end
endmodule
